/* File: core/dmfs_defs.svh */
// constants for the drive mode and feedback selection block
// Summary of operation
// - mode bit 0: 0 open loop, 1 closed
// - loop selection frozen while operation enabled
// - bit 1 emulates velocity control by S-ramp
// - bit 2 enables automatic brake control
// - bit 3 reduces current in open loop
// - bit 4 aligns rotor, then closes immediately
// - without auto alignment, wait for index pulse
// - encoder without index always forces auto alignment
// - bit 5 in torque modes: torque controller only
// - bit 6 selects brushless DC motor type
// - bit 7 slow speed, only with closed loop
// - selection writes apply outside operation enabled, frozen while enabled
// - selection entry zero reads source count 03
// - mask bits position, velocity, commutation; reset 00
// - entry one is always the sensorless source
// - scan from sensor 2 upward, first wins
// - open loop ignores commutation bit, keeps others
// - read-only map 3380, 3390, 33a0, count 03
// - map entry n names source n configuration
`ifndef DMFS_DEFS_SVH
`define DMFS_DEFS_SVH

// ------------------------------------------------------------------
// object addresses
// ------------------------------------------------------------------
`define DMFS_IDX_MODE 16'h3202
`define DMFS_IDX_SELECT 16'h3203
`define DMFS_IDX_MAP 16'h3204
`define DMFS_SUB_COUNT 8'h00

// ------------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------------
`define DMFS_BIT_LOOP 0
`define DMFS_BIT_RAMP 1
`define DMFS_BIT_BRAKE 2
`define DMFS_BIT_CURRENT_REDUCE_ENABLE 3
`define DMFS_BIT_ALIGN 4
`define DMFS_BIT_TORQUE 5
`define DMFS_BIT_BLDC 6
`define DMFS_BIT_SLOW 7
`define DMFS_ROLE_POS 0
`define DMFS_ROLE_VEL 1
`define DMFS_ROLE_COM 2
`define DMFS_MODE_RESET 32'h0000_0000
`define DMFS_MASK_RESET 8'h00
`define DMFS_NUM_SRC 3
`define DMFS_SRC_COUNT 8'h03
`define DMFS_MAP_SRC1 16'h3380
`define DMFS_MAP_SRC2 16'h3390
`define DMFS_MAP_SRC3 16'h33a0
`define DMFS_SCAN_FIRST 2

`endif

/* File: core/dmfs_mode_select.sv */
// drive mode word, feedback role selection and source map objects
`timescale 1ns/100ps
`default_nettype none
`include "dmfs_defs.svh"
module dmfs_mode_select (
  input wire logic clock_in,
  input wire logic rst_n_in,
  // object access port
  input wire logic [15:0] obj_index_in,
  input wire logic [7:0] obj_subindex_in,
  input wire logic obj_wr_in,
  input wire logic obj_rd_in,
  input wire logic [31:0] obj_wdata_in,
  output logic [31:0] obj_rdata_out,
  output logic obj_ack_out,
  output logic obj_err_out,
  // drive context, same clock
  input wire logic op_enabled_in,
  input wire logic torque_mode_in,
  input wire logic enc_has_index_in,
  input wire logic align_done_in,
  // encoder index pin, asynchronous
  input wire logic enc_index_in,
  // controller configuration
  output logic loop_closed_out,
  output logic commutation_closed_out,
  output logic align_active_out,
  output logic speed_ramp_emulation_out,
  output logic brake_auto_out,
  output logic current_reduce_enable_out,
  output logic torque_only_out,
  output logic velocity_overlay_out,
  output logic motor_bldc_out,
  output logic slow_speed_out,
  output dmfs_pkg::dmfs_src_t pos_src_out,
  output dmfs_pkg::dmfs_src_t vel_src_out,
  output dmfs_pkg::dmfs_src_t com_src_out
);
  import dmfs_pkg::*;

  // ------------------------------------------------------------------
  // state and helper nets
  // ------------------------------------------------------------------
  dmfs_state_s state;
  dmfs_state_s next_state;
  logic index_level;
  logic index_seen;
  logic op_entry;
  logic auto_align;
  logic [7:0] sub_sel;
  dmfs_src_t scan_pos;
  dmfs_src_t scan_vel;
  dmfs_src_t scan_com;

  // index pin crosses in from the encoder
  dmfs_pin_sync u_index_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .pin_in(enc_index_in),
    .level_out(index_level)
  );

  // ------------------------------------------------------------------
  // role searches over the masks in force
  // ------------------------------------------------------------------
  dmfs_role_scan #(
    .ROLE_BIT(`DMFS_ROLE_POS)
  ) u_scan_pos (
    .masks_in(state.mask_active),
    .src_out(scan_pos)
  );

  dmfs_role_scan #(
    .ROLE_BIT(`DMFS_ROLE_VEL)
  ) u_scan_vel (
    .masks_in(state.mask_active),
    .src_out(scan_vel)
  );

  dmfs_role_scan #(
    .ROLE_BIT(`DMFS_ROLE_COM)
  ) u_scan_com (
    .masks_in(state.mask_active),
    .src_out(scan_com)
  );

  // ------------------------------------------------------------------
  // events derived from registered context
  // ------------------------------------------------------------------
  // rising edge of the synchronised index level
  assign index_seen = index_level & ~state.index_q;
  // drive has just moved into operation enabled
  assign op_entry = op_enabled_in & ~state.op_q;
  // an encoder without index cannot be waited for
  assign auto_align = state.mode_word[`DMFS_BIT_ALIGN] |
                      ~enc_has_index_in;
  // subindex passed through unchanged for table lookups
  assign sub_sel = obj_subindex_in;

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.ack = 1'b0;
    next_state.err = 1'b0;
    next_state.op_q = op_enabled_in;
    next_state.index_q = index_level;

    // object writes; a write and a read together count as a write
    if (obj_wr_in) begin
      next_state.ack = 1'b1;
      next_state.rdata = '0;
      if (obj_index_in == `DMFS_IDX_MODE &&
          obj_subindex_in == `DMFS_SUB_COUNT) begin
        next_state.mode_word = obj_wdata_in;
      end else if (obj_index_in == `DMFS_IDX_SELECT &&
                   sub_sel != `DMFS_SUB_COUNT &&
                   sub_sel <= `DMFS_SRC_COUNT) begin
        // shadow only; entry 1 stays the sensorless source
        next_state.mask_shadow[sub_sel[1:0]-2'h1] =
          obj_wdata_in[7:0];
      end else begin
        // count entries, the map and unknown objects refuse writes
        next_state.err = 1'b1;
      end
    end else if (obj_rd_in) begin
      next_state.ack = 1'b1;
      next_state.rdata = '0;
      unique case (obj_index_in)
        `DMFS_IDX_MODE: begin
          if (obj_subindex_in == `DMFS_SUB_COUNT) begin
            next_state.rdata = state.mode_word;
          end else begin
            next_state.err = 1'b1;
          end
        end
        `DMFS_IDX_SELECT: begin
          if (sub_sel == `DMFS_SUB_COUNT) begin
            next_state.rdata[7:0] = `DMFS_SRC_COUNT;
          end else if (sub_sel <= `DMFS_SRC_COUNT) begin
            next_state.rdata[7:0] =
              state.mask_shadow[sub_sel[1:0]-2'h1];
          end else begin
            next_state.err = 1'b1;
          end
        end
        `DMFS_IDX_MAP: begin
          // entry n names the configuration object of source n
          unique case (sub_sel)
            8'h00: next_state.rdata[7:0] = `DMFS_SRC_COUNT;
            8'h01: next_state.rdata[15:0] = `DMFS_MAP_SRC1;
            8'h02: next_state.rdata[15:0] = `DMFS_MAP_SRC2;
            8'h03: next_state.rdata[15:0] = `DMFS_MAP_SRC3;
            default: next_state.err = 1'b1;
          endcase
        end
        default: begin
          next_state.err = 1'b1;
        end
      endcase
    end

    // loop choice is latched only outside operation enabled
    if (!op_enabled_in) begin
      next_state.loop_applied =
        state.mode_word[`DMFS_BIT_LOOP];
    end

    // masks track the shadow until operation is enabled, then
    // freeze; a later entry picks up whatever was buffered
    if (!op_enabled_in || op_entry) begin
      next_state.mask_active = state.mask_shadow;
    end

    // commutation progress towards closed loop
    unique case (state.comm)
      DMFS_CM_OPEN: begin
        if (state.loop_applied) begin
          if (auto_align) begin
            next_state.comm = DMFS_CM_ALIGN;
          end else begin
            next_state.comm = DMFS_CM_WAIT_INDEX;
          end
        end
      end
      DMFS_CM_ALIGN: begin
        // no index needed once the open-loop alignment is done
        if (align_done_in) begin
          next_state.comm = DMFS_CM_CLOSED;
        end
      end
      DMFS_CM_WAIT_INDEX: begin
        // stays open loop for up to one shaft revolution
        if (index_seen) begin
          next_state.comm = DMFS_CM_CLOSED;
        end
      end
      DMFS_CM_CLOSED: begin
        next_state.comm = DMFS_CM_CLOSED;
      end
    endcase
    if (!state.loop_applied) begin
      next_state.comm = DMFS_CM_OPEN;
    end

    // role assignment; commutation only counts in closed loop
    next_state.pos_src = scan_pos;
    next_state.vel_src = scan_vel;
    next_state.com_src = state.loop_applied ? scan_com : '0;

    // mode flags steering the controllers
    next_state.ramp_emul =
      state.mode_word[`DMFS_BIT_RAMP];
    next_state.brake_auto =
      state.mode_word[`DMFS_BIT_BRAKE];
    next_state.cur_reduce = state.mode_word[`DMFS_BIT_CURRENT_REDUCE_ENABLE] &
                            (state.comm != DMFS_CM_CLOSED);
    next_state.torque_only = torque_mode_in &
                             state.mode_word[`DMFS_BIT_TORQUE];
    next_state.vel_overlay = torque_mode_in &
                             ~state.mode_word[`DMFS_BIT_TORQUE];
    next_state.bldc = state.mode_word[`DMFS_BIT_BLDC];
    // held off until commutation really runs closed loop
    next_state.slow = state.mode_word[`DMFS_BIT_SLOW] &
                      (state.comm == DMFS_CM_CLOSED);
  end

  // ------------------------------------------------------------------
  // state register, synchronous reset to documented presets
  // ------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state <= '0;
      state.mode_word <= `DMFS_MODE_RESET;
      state.mask_shadow <= {`DMFS_NUM_SRC{`DMFS_MASK_RESET}};
      state.mask_active <= {`DMFS_NUM_SRC{`DMFS_MASK_RESET}};
      state.comm <= DMFS_CM_OPEN;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------------
  // outputs, all straight from the state register
  // ------------------------------------------------------------------
  assign obj_rdata_out = state.rdata;
  assign obj_ack_out = state.ack;
  assign obj_err_out = state.err;
  assign loop_closed_out = state.loop_applied;
  assign commutation_closed_out = (state.comm == DMFS_CM_CLOSED);
  assign align_active_out = (state.comm == DMFS_CM_ALIGN);
  assign speed_ramp_emulation_out = state.ramp_emul;
  assign brake_auto_out = state.brake_auto;
  assign current_reduce_enable_out = state.cur_reduce;
  assign torque_only_out = state.torque_only;
  assign velocity_overlay_out = state.vel_overlay;
  assign motor_bldc_out = state.bldc;
  assign slow_speed_out = state.slow;
  assign pos_src_out = state.pos_src;
  assign vel_src_out = state.vel_src;
  assign com_src_out = state.com_src;
endmodule
`default_nettype wire

/* File: core/dmfs_pin_sync.sv */
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/100ps
`default_nettype none
module dmfs_pin_sync (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  output logic level_out
);
  import dmfs_pkg::*;

  dmfs_sync_s state;
  dmfs_sync_s next_state;

  // ------------------------------------------------------------------
  // stage chain; level moves only when stages two and three agree
  // ------------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.stage = {state.stage[1:0], pin_in};
    if (state.stage[1] == state.stage[2]) begin
      next_state.level = state.stage[2];
    end
  end

  // synchronous reset, constants only
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign level_out = state.level;
endmodule
`default_nettype wire

/* File: core/dmfs_pkg.sv */
// types shared by the drive mode and feedback selection block
`include "dmfs_defs.svh"
package dmfs_pkg;
  // source number 1..3, zero means no source
  typedef logic [1:0] dmfs_src_t;
  typedef logic [`DMFS_NUM_SRC-1:0][7:0] dmfs_masks_t;

  // commutation progress, gray along both paths to closed
  typedef enum logic [1:0] {
    DMFS_CM_OPEN = 2'b00,
    DMFS_CM_ALIGN = 2'b01,
    DMFS_CM_CLOSED = 2'b11,
    DMFS_CM_WAIT_INDEX = 2'b10
  } dmfs_comm_e;

  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } dmfs_sync_s;

  typedef struct packed {
    logic [31:0] mode_word;
    logic loop_applied;
    dmfs_masks_t mask_shadow;
    dmfs_masks_t mask_active;
    logic op_q;
    logic index_q;
    dmfs_comm_e comm;
    dmfs_src_t pos_src;
    dmfs_src_t vel_src;
    dmfs_src_t com_src;
    logic ramp_emul;
    logic brake_auto;
    logic cur_reduce;
    logic torque_only;
    logic vel_overlay;
    logic bldc;
    logic slow;
    logic [31:0] rdata;
    logic ack;
    logic err;
  } dmfs_state_s;
endpackage

/* File: core/dmfs_role_scan.sv */
// priority search of feedback role masks for one controller role
`timescale 1ns/100ps
`default_nettype none
`include "dmfs_defs.svh"
module dmfs_role_scan #(
  parameter int ROLE_BIT = 0
) (
  input wire dmfs_pkg::dmfs_masks_t masks_in,
  output dmfs_pkg::dmfs_src_t src_out
);
  import dmfs_pkg::*;

  // ------------------------------------------------------------------
  // walk downward so the lowest matching sensor is the one kept;
  // sensor 1 (sensorless) never takes part in the search
  // ------------------------------------------------------------------
  always_comb begin
    src_out = '0;
    for (int i = `DMFS_NUM_SRC; i >= `DMFS_SCAN_FIRST; i--) begin
      if (masks_in[i-1][ROLE_BIT]) begin
        src_out = dmfs_src_t'(i);
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/dmfs_mode_select_props.sv */
// assertion checker for the drive mode and feedback selection block
`timescale 1ns/100ps
`default_nettype none
module dmfs_mode_select_props (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic obj_wr_in,
  input wire logic obj_rd_in,
  input wire logic op_enabled_in,
  input wire logic torque_mode_in,
  input wire logic obj_ack_out,
  input wire logic obj_err_out,
  input wire logic loop_closed_out,
  input wire logic commutation_closed_out,
  input wire logic current_reduce_enable_out,
  input wire logic torque_only_out,
  input wire logic velocity_overlay_out,
  input wire logic slow_speed_out,
  input wire dmfs_pkg::dmfs_src_t pos_src_out,
  input wire dmfs_pkg::dmfs_src_t vel_src_out,
  input wire dmfs_pkg::dmfs_src_t com_src_out
);
  import dmfs_pkg::*;
  // one clock domain, so clocking and disable are shared
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  chk_ack_follows: assert property ((obj_wr_in || obj_rd_in) |=> obj_ack_out)
    else $error("strobe not answered by ack");
  chk_ack_caused: assert property (
    obj_ack_out |-> $past(obj_wr_in) || $past(obj_rd_in))
    else $error("ack without a request");
  chk_err_with_ack: assert property (obj_err_out |-> obj_ack_out)
    else $error("err pulse without ack");
  chk_loop_frozen: assert property (
    op_enabled_in [*3] |-> $stable(loop_closed_out))
    else $error("loop select moved while operation enabled");
  chk_torque_idle: assert property (
    !torque_mode_in [*3] |-> !torque_only_out && !velocity_overlay_out)
    else $error("torque flags outside torque modes");
  chk_torque_excl: assert property (
    !(torque_only_out && velocity_overlay_out))
    else $error("torque only and overlay together");
  chk_slow_closed: assert property (
    slow_speed_out |-> commutation_closed_out || $past(commutation_closed_out))
    else $error("slow speed without closed loop");
  chk_reduce_open: assert property (
    commutation_closed_out && $past(commutation_closed_out)
    |-> !current_reduce_enable_out)
    else $error("current reduction in closed loop");
  chk_open_no_comm: assert property (
    !loop_closed_out [*3] |-> com_src_out == 2'h0)
    else $error("commutation source in open loop");
  chk_open_state: assert property (
    !loop_closed_out [*2] |-> !commutation_closed_out)
    else $error("commutation closed with open loop");
  chk_no_sensor1: assert property (
    pos_src_out != 2'h1 && vel_src_out != 2'h1 && com_src_out != 2'h1)
    else $error("sensorless source assigned a role");
endmodule
bind dmfs_mode_select dmfs_mode_select_props u_props (
  .clock_in(clock_in), .rst_n_in(rst_n_in), .obj_wr_in(obj_wr_in),
  .obj_rd_in(obj_rd_in), .op_enabled_in(op_enabled_in),
  .torque_mode_in(torque_mode_in), .obj_ack_out(obj_ack_out),
  .obj_err_out(obj_err_out), .loop_closed_out(loop_closed_out),
  .commutation_closed_out(commutation_closed_out),
  .current_reduce_enable_out(current_reduce_enable_out),
  .torque_only_out(torque_only_out),
  .velocity_overlay_out(velocity_overlay_out),
  .slow_speed_out(slow_speed_out), .pos_src_out(pos_src_out),
  .vel_src_out(vel_src_out), .com_src_out(com_src_out));
`default_nettype wire

/* File: testbench/dmfs_motor_model.sv */
// motor model: alignment completion and encoder index pulses
`timescale 1ns/100ps
`default_nettype none
module dmfs_motor_model #(
  parameter int REV_CYCLES = 40,
  parameter int ALIGN_CYCLES = 12
) (
  input wire logic clock_in,
  input wire logic align_req_in,
  output logic index_out,
  output logic align_done_out
);
  int rev_cnt = 0;
  int align_cnt = 0;
  initial begin
    index_out = 1'b0;
    align_done_out = 1'b0;
  end
  // index once a revolution, 4 cycles wide so the pin filter agrees
  always @(posedge clock_in) begin
    rev_cnt <= (rev_cnt + 1) % REV_CYCLES;
    index_out <= #3 rev_cnt >= REV_CYCLES - 4;
  end
  // alignment ends some cycles after the request, held until dropped
  always @(posedge clock_in) begin
    align_cnt <= align_req_in ? align_cnt + 1 : 0;
    align_done_out <= align_req_in && align_cnt >= ALIGN_CYCLES;
  end
endmodule
`default_nettype wire

/* File: testbench/tb_dmfs_mode_select.sv */
// self-checking bench for the drive mode and feedback selection block
`timescale 1ns/100ps
`default_nettype none
module tb_dmfs_mode_select;
  import dmfs_pkg::*;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [15:0] idx = 16'h0;
  logic [7:0] sub = 8'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic op = 1'b0;
  logic tq = 1'b0;
  logic has_idx = 1'b1;
  logic index_pin, align_done, ack, err, loop_c, com_c, align_a;
  logic ramp, brake, creduce, tonly, vover, bldc, slow;
  logic [31:0] rdata;
  dmfs_src_t pos_s, vel_s, com_s;
  logic [31:0] map [4] = '{32'h3, 32'h3380, 32'h3390, 32'h33a0};
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int i;
  dmfs_mode_select u_dut (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .obj_index_in(idx),
    .obj_subindex_in(sub), .obj_wr_in(wr), .obj_rd_in(rd),
    .obj_wdata_in(wdata), .obj_rdata_out(rdata), .obj_ack_out(ack),
    .obj_err_out(err), .op_enabled_in(op), .torque_mode_in(tq),
    .enc_has_index_in(has_idx), .align_done_in(align_done),
    .enc_index_in(index_pin), .loop_closed_out(loop_c),
    .commutation_closed_out(com_c), .align_active_out(align_a),
    .speed_ramp_emulation_out(ramp), .brake_auto_out(brake),
    .current_reduce_enable_out(creduce), .torque_only_out(tonly),
    .velocity_overlay_out(vover), .motor_bldc_out(bldc),
    .slow_speed_out(slow), .pos_src_out(pos_s), .vel_src_out(vel_s),
    .com_src_out(com_s));
  dmfs_motor_model u_motor (.clock_in(clock_in), .align_req_in(align_a),
    .index_out(index_pin), .align_done_out(align_done));
  always #12.5 clock_in = ~clock_in;
  task automatic complete_run();
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // a hang is cut short well past the expected run length
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      complete_run();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp,
      input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clock_in);
    #2;
  endtask
  // one object access: strobe for one cycle, answer in the next
  task automatic obj(input logic w, input logic [15:0] i,
      input logic [7:0] s, input logic [31:0] d, input logic e,
      input logic [31:0] exp);
    step(1);
    idx = i;
    sub = s;
    wdata = d;
    wr = w;
    rd = !w;
    step(1);
    wr = 1'b0;
    rd = 1'b0;
    chk("ack", 1, ack);
    chk("err", e, err);
    if (!w && !e) chk("rdata", exp, rdata);
  endtask
  task automatic wait_closed();
    for (int k = 0; k < 80 && com_c !== 1'b1; k++) step(1);
  endtask
  initial begin
    step(4);
    rst_n_in = 1'b1;
    // refused accesses first; the refused write must leave the word alone
    obj(1, 16'h3202, 8'h1, 32'h1, 1, 0);
    obj(0, 16'h3202, 8'h0, 0, 0, 0);
    obj(0, 16'h3202, 8'h1, 0, 1, 0);
    obj(0, 16'h3203, 8'h4, 0, 1, 0);
    obj(1, 16'h3203, 8'h4, 32'h7, 1, 0);
    obj(0, 16'h3204, 8'h4, 0, 1, 0);
    for (i = 0; i < 4; i++) begin
      obj(0, 16'h3203, i[7:0], 0, 0, i == 0 ? 3 : 0);
      obj(0, 16'h3204, i[7:0], 0, 0, map[i]);
    end
    obj(1, 16'h3204, 8'h1, 32'h1234, 1, 0);
    obj(0, 16'h3204, 8'h1, 0, 0, 32'h3380);
    obj(1, 16'h3203, 8'h0, 32'h7, 1, 0);
    obj(0, 16'h3203, 8'h0, 0, 0, 32'h3);
    obj(0, 16'h3205, 8'h0, 0, 1, 0);
    // mode flags with a torque mode running
    tq = 1'b1;
    obj(1, 16'h3202, 8'h0, 32'h6e, 0, 0);
    step(2);
    chk("ramp", 1, ramp);
    chk("brake", 1, brake);
    chk("creduce", 1, creduce);
    chk("tonly", 1, tonly);
    chk("vover", 0, vover);
    chk("bldc", 1, bldc);
    chk("loop", 0, loop_c);
    obj(0, 16'h3202, 8'h0, 0, 0, 32'h6e);
    obj(1, 16'h3202, 8'h0, 32'h0, 0, 0);
    step(2);
    chk("vover", 1, vover);
    chk("bldc", 0, bldc);
    chk("tonly", 0, tonly);
    chk("ramp", 0, ramp);
    chk("brake", 0, brake);
    chk("creduce", 0, creduce);
    tq = 1'b0;
    // role masks in open loop; sensorless mask must not be searched
    obj(1, 16'h3203, 8'h1, 32'h7, 0, 0);
    obj(1, 16'h3203, 8'h2, 32'hfa, 0, 0);
    obj(1, 16'h3203, 8'h3, 32'h7, 0, 0);
    step(2);
    chk("pos", 3, pos_s);
    chk("vel", 2, vel_s);
    chk("com", 0, com_s);
    obj(0, 16'h3203, 8'h2, 0, 0, 32'hfa);
    // closed loop with alignment, then slow speed
    obj(1, 16'h3202, 8'h0, 32'h19, 0, 0);
    step(3);
    chk("loop", 1, loop_c);
    chk("align", 1, align_a);
    wait_closed();
    chk("closed", 1, com_c);
    // the reduction flag follows the closed state one edge later
    step(1);
    chk("creduce", 0, creduce);
    chk("com", 3, com_s);
    obj(1, 16'h3202, 8'h0, 32'h99, 0, 0);
    step(3);
    chk("slow", 1, slow);
    // changes while operation enabled wait for its end
    op = 1'b1;
    step(2);
    obj(1, 16'h3202, 8'h0, 32'h18, 0, 0);
    obj(1, 16'h3203, 8'h3, 32'h0, 0, 0);
    step(3);
    chk("loop", 1, loop_c);
    chk("pos", 3, pos_s);
    op = 1'b0;
    step(3);
    chk("loop", 0, loop_c);
    chk("pos", 0, pos_s);
    chk("closed", 0, com_c);
    // without the alignment bit the index pulse closes the loop, or alignment does if the encoder has no index
    obj(1, 16'h3202, 8'h0, 32'h1, 0, 0);
    step(3);
    chk("align", 0, align_a);
    wait_closed();
    chk("closed", 1, com_c);
    obj(1, 16'h3202, 8'h0, 32'h0, 0, 0);
    has_idx = 1'b0;
    obj(1, 16'h3202, 8'h0, 32'h1, 0, 0);
    step(3);
    chk("align", 1, align_a);
    wait_closed();
    chk("closed", 1, com_c);
    // a reset in mid-run brings every preset back
    rst_n_in = 1'b0;
    step(2);
    rst_n_in = 1'b1;
    chk("loop", 0, loop_c);
    chk("closed", 0, com_c);
    obj(0, 16'h3202, 8'h0, 0, 0, 0);
    obj(0, 16'h3203, 8'h2, 0, 0, 0);
    complete_run();
  end
endmodule
`default_nettype wire
